// File: rmpc_cfg.sv
// Radio mode and packet coding configuration bank with APB slave.
// Assumes the radio state code and packet events come from pclk logic.
//
// Operation
// - Mode bit 7 enables smart wake operation
// - Mode bit 6 requests IF filter calibration on each off-to-on move
// - Mode bit 5 enables RSSI qualification during low power wake
// - Mode bit 4 turns to receive after transmit end, packet mode only
// - Mode bit 3 turns to transmit after valid receive, packet mode only
// - Mode bit 2 selects custom synthesizer lock time, else default
// - Mode bit 1 drives LNA pin high in receive, low otherwise awake
// - Mode bit 0 drives PA pin high in transmit, low otherwise awake
// - Tolerance 12 down to 8 allows zero to four bad pairs of 12
// - Tolerance zero disables preamble detection
// - Coding bit 6 enables Manchester coding both directions
// - Coding bit 5 selects programmable CRC, else default CRC
// - Coding bit 4 enables 8b/10b coding both directions
// - Coding bit 3 enables whitening and dewhitening
// - Symbol width 0 gives 8-bit symbols, 1 gives 10-bit
// - Preamble length in bits is eight times the byte count
// - Low seven bits hold the I/Q amplitude trim, top bit reserved
// - Frequency lock after preamble; sync lock only with tolerance zero
`timescale 1ns/1ps
module rmpc_cfg (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rmpc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] radio_state,
  input wire logic packet_mode,
  input wire logic tx_packet_done,
  input wire logic rx_packet_valid,
  input wire logic [1:0] freq_tracking_lock_mode,
  output logic smart_wake_enable,
  output logic wake_rssi_qualify,
  output logic if_filter_cal_start,
  output logic turnaround_to_rx,
  output logic turnaround_to_tx,
  output logic custom_lock_time_enable,
  output logic lock_after_preamble,
  output logic lock_on_sync,
  output logic [6:0] iq_amplitude_trim,
  output rmpc_pkg::rmpc_coding_out_t coding,
  output logic lna_pin_out,
  output logic lna_pin_oe,
  output logic pa_pin_out,
  output logic pa_pin_oe
);

  logic [7:0] iq_gain_trim;
  rmpc_pkg::rmpc_behavior_t radio_behavior_ctrl;
  logic [7:0] preamble_error_tolerance;
  rmpc_pkg::rmpc_coding_t line_coding_cfg;
  logic [7:0] preamble_byte_count;
  rmpc_pkg::rmpc_state_t state_q;
  rmpc_pkg::rmpc_state_t state_now;

  function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [7:0] wd,
                                            input logic lane, input logic [7:0] mask);
    merge_byte = lane ? (wd & mask) : old;
  endfunction : merge_byte

  function automatic logic hit(input logic [rmpc_pkg::ADDR_W-1:0] a,
                               input logic [11:0] idx);
    hit = (a[rmpc_pkg::ADDR_W-1:2] == idx) && (a[1:0] == rmpc_pkg::ADDR_LSB_ZERO);
  endfunction : hit

  // Bus decode; zero wait state, unmapped addresses answer with an error
  wire logic sel_iq = hit(paddr, rmpc_pkg::IDX_IQ_GAIN_TRIM);
  wire logic sel_mode = hit(paddr, rmpc_pkg::IDX_RADIO_BEHAVIOR_CTRL);
  wire logic sel_tol = hit(paddr, rmpc_pkg::IDX_PREAMBLE_ERROR_TOLERANCE);
  wire logic sel_code = hit(paddr, rmpc_pkg::IDX_LINE_CODING_CFG);
  wire logic sel_len = hit(paddr, rmpc_pkg::IDX_PREAMBLE_BYTE_COUNT);
  wire logic sel_any = sel_iq | sel_mode | sel_tol | sel_code | sel_len;
  wire logic access = psel & penable;
  wire logic wr_en = access & pwrite & sel_any;
  wire logic lane0 = pstrb[0];

  assign pready = 1'b1;
  assign pslverr = access & ~sel_any;

  // Reserved bits are masked off so they always read back zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      iq_gain_trim <= rmpc_pkg::RST_IQ_GAIN_TRIM;
      radio_behavior_ctrl <= rmpc_pkg::RST_BEHAVIOR;
      preamble_error_tolerance <= rmpc_pkg::RST_PREAMBLE_TOL;
      line_coding_cfg <= rmpc_pkg::RST_LINE_CODING;
      preamble_byte_count <= rmpc_pkg::RST_PREAMBLE_BYTES;
    end else if (wr_en) begin
      if (sel_iq) iq_gain_trim <= merge_byte(iq_gain_trim, pwdata[7:0], lane0,
                                             rmpc_pkg::MASK_IQ_GAIN_TRIM);
      if (sel_mode) radio_behavior_ctrl <= merge_byte(radio_behavior_ctrl, pwdata[7:0], lane0,
                                                      rmpc_pkg::MASK_FULL);
      if (sel_tol) preamble_error_tolerance <= merge_byte(preamble_error_tolerance,
                                                          pwdata[7:0], lane0,
                                                          rmpc_pkg::MASK_PREAMBLE_TOL);
      if (sel_code) line_coding_cfg <= merge_byte(line_coding_cfg, pwdata[7:0], lane0,
                                                  rmpc_pkg::MASK_LINE_CODING);
      if (sel_len) preamble_byte_count <= merge_byte(preamble_byte_count, pwdata[7:0], lane0,
                                                     rmpc_pkg::MASK_FULL);
    end
  end

  wire logic [7:0] rd_byte = sel_iq ? iq_gain_trim :
                             sel_mode ? radio_behavior_ctrl :
                             sel_tol ? preamble_error_tolerance :
                             sel_code ? line_coding_cfg :
                             sel_len ? preamble_byte_count : 8'h00;

  // Read data registered in the setup cycle so it is a flop at the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= {24'h00_0000, rd_byte};
    end
  end

  // Radio state tracking for edge events
  always_comb begin
    case (radio_state)
      3'b000: state_now = rmpc_pkg::RMPC_ST_SLEEP;
      3'b001: state_now = rmpc_pkg::RMPC_ST_OFF;
      3'b010: state_now = rmpc_pkg::RMPC_ST_ON;
      3'b011: state_now = rmpc_pkg::RMPC_ST_RX;
      3'b100: state_now = rmpc_pkg::RMPC_ST_TX;
      default: state_now = rmpc_pkg::RMPC_ST_ON;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) state_q <= rmpc_pkg::RMPC_ST_SLEEP;
    else state_q <= state_now;
  end

  wire logic off_to_on = (state_q == rmpc_pkg::RMPC_ST_OFF) &&
                         (state_now == rmpc_pkg::RMPC_ST_ON);
  wire logic awake = (state_now != rmpc_pkg::RMPC_ST_SLEEP);
  wire logic in_rx = (state_now == rmpc_pkg::RMPC_ST_RX);
  wire logic in_tx = (state_now == rmpc_pkg::RMPC_ST_TX);

  // Tolerance decode: errors allowed = 12 - code, valid for 8..12
  wire logic [3:0] tol = preamble_error_tolerance[3:0];
  wire logic tol_valid = (tol >= rmpc_pkg::TOL_MIN_VALID) && (tol <= rmpc_pkg::TOL_MAX_VALID);
  wire logic [3:0] tol_errors = tol_valid ? 4'(rmpc_pkg::TOL_PAIRS_OBSERVED - tol) : 4'h0;

  wire logic [3:0] sym_bits = (line_coding_cfg.symbol_width == rmpc_pkg::SYM_10BIT) ?
                              rmpc_pkg::SYM_BITS_10 : rmpc_pkg::SYM_BITS_8;
  wire logic lock_mode = (freq_tracking_lock_mode == rmpc_pkg::AFC_LOCK);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smart_wake_enable <= 1'b0;
      wake_rssi_qualify <= 1'b0;
      if_filter_cal_start <= 1'b0;
      turnaround_to_rx <= 1'b0;
      turnaround_to_tx <= 1'b0;
      custom_lock_time_enable <= 1'b0;
      lock_after_preamble <= 1'b0;
      lock_on_sync <= 1'b0;
      iq_amplitude_trim <= 7'h00;
      coding <= '0;
      lna_pin_out <= 1'b0;
      lna_pin_oe <= 1'b0;
      pa_pin_out <= 1'b0;
      pa_pin_oe <= 1'b0;
    end else begin
      smart_wake_enable <= radio_behavior_ctrl.smart_wake_enable;
      wake_rssi_qualify <= radio_behavior_ctrl.wake_rssi_qualify;
      if_filter_cal_start <= off_to_on & radio_behavior_ctrl.if_filter_cal_enable;
      turnaround_to_rx <= tx_packet_done & packet_mode &
                          radio_behavior_ctrl.tx_then_rx_turnaround;
      turnaround_to_tx <= rx_packet_valid & packet_mode &
                          radio_behavior_ctrl.rx_then_tx_turnaround;
      custom_lock_time_enable <= radio_behavior_ctrl.custom_lock_time_enable;
      lock_after_preamble <= lock_mode & (tol != rmpc_pkg::TOL_OFF);
      lock_on_sync <= lock_mode & (tol == rmpc_pkg::TOL_OFF);
      iq_amplitude_trim <= iq_gain_trim[6:0];
      coding.biphase_coding_enable <= line_coding_cfg.biphase_coding_enable;
      coding.custom_crc_select <= line_coding_cfg.custom_crc_select;
      coding.dc_balanced_coding_enable <= line_coding_cfg.dc_balanced_coding_enable;
      coding.whitening_enable <= line_coding_cfg.whitening_enable;
      coding.symbol_bits <= sym_bits;
      coding.preamble_detect_enable <= (tol != rmpc_pkg::TOL_OFF);
      coding.preamble_errors_allowed <= tol_errors;
      coding.preamble_bits <= {preamble_byte_count, 3'h0};
      lna_pin_oe <= radio_behavior_ctrl.lna_control_enable & awake;
      lna_pin_out <= radio_behavior_ctrl.lna_control_enable & awake & in_rx;
      pa_pin_oe <= radio_behavior_ctrl.pa_control_enable & awake;
      pa_pin_out <= radio_behavior_ctrl.pa_control_enable & awake & in_tx;
    end
  end

  // Checks
  sw_wake_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && sel_mode && lane0 |=> ##1 smart_wake_enable == $past(pwdata[7], 2))
    else $error("smart wake does not follow mode bit");
  cal_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    if_filter_cal_start |-> $past(off_to_on) && $past(radio_behavior_ctrl.if_filter_cal_enable))
    else $error("calibration start without off-to-on move");
  cal_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    off_to_on && radio_behavior_ctrl.if_filter_cal_enable |=> if_filter_cal_start)
    else $error("calibration missed on off-to-on move");
  rssi_qual_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 wake_rssi_qualify == $past(radio_behavior_ctrl.wake_rssi_qualify))
    else $error("rssi qualify mismatch");
  to_rx_a: assert property (@(posedge pclk) disable iff (!presetn)
    turnaround_to_rx |-> $past(packet_mode) && $past(tx_packet_done))
    else $error("turnaround to receive outside packet mode");
  to_tx_a: assert property (@(posedge pclk) disable iff (!presetn)
    turnaround_to_tx |-> $past(packet_mode) && $past(rx_packet_valid))
    else $error("turnaround to transmit without valid packet");
  lock_time_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 custom_lock_time_enable == $past(radio_behavior_ctrl.custom_lock_time_enable))
    else $error("lock time select mismatch");
  lna_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
    lna_pin_out |-> lna_pin_oe && $past(in_rx))
    else $error("lna pin high outside receive");
  pa_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
    pa_pin_out |-> pa_pin_oe && $past(in_tx))
    else $error("pa pin high outside transmit");
  tol_errs_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(tol) == rmpc_pkg::TOL_MIN_VALID |-> coding.preamble_errors_allowed == 4'h4)
    else $error("tolerance eight must allow four pairs");
  det_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    coding.preamble_detect_enable |-> $past(tol) != rmpc_pkg::TOL_OFF)
    else $error("preamble detection with tolerance zero");
  sym_width_a: assert property (@(posedge pclk) disable iff (!presetn)
    coding.symbol_bits == rmpc_pkg::SYM_BITS_10 |->
      $past(line_coding_cfg.symbol_width) == rmpc_pkg::SYM_10BIT)
    else $error("ten-bit symbols without width code one");
  pre_bits_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 coding.preamble_bits == {$past(preamble_byte_count), 3'h0})
    else $error("preamble bits not eight times bytes");
  iq_resv_a: assert property (@(posedge pclk) disable iff (!presetn)
    iq_gain_trim[7] == 1'b0)
    else $error("iq reserved bit set");
  sync_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(lock_on_sync && lock_after_preamble))
    else $error("both lock points active");
  code_bits_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 {coding.biphase_coding_enable, coding.custom_crc_select,
         coding.dc_balanced_coding_enable, coding.whitening_enable} ==
        $past(line_coding_cfg[6:3]))
    else $error("coding flags mismatch");


  // Bus response and write protection
  bad_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    access && !sel_any |-> pslverr)
    else $error("unmapped access without error");
  good_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    access && sel_any |-> !pslverr)
    else $error("mapped access flagged as error");
  ready_high_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready)
    else $error("ready not high");
  err_no_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && !sel_any |=> $stable(radio_behavior_ctrl) && $stable(iq_gain_trim))
    else $error("refused write changed a register");
  strb_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && sel_mode && !lane0 |=> $stable(radio_behavior_ctrl))
    else $error("write without lane strobe landed");
  rd_upper_a: assert property (@(posedge pclk) disable iff (!presetn)
    prdata[31:8] == '0)
    else $error("read data upper bits not zero");
  tol_resv_a: assert property (@(posedge pclk) disable iff (!presetn)
    preamble_error_tolerance[7:4] == '0)
    else $error("tolerance reserved bits set");
  code_resv_a: assert property (@(posedge pclk) disable iff (!presetn)
    line_coding_cfg.reserved == 1'b0)
    else $error("coding reserved bit set");

  // Mode outputs against the register one edge earlier
  wake_on_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 smart_wake_enable == $past(radio_behavior_ctrl.smart_wake_enable))
    else $error("smart wake output mismatch");
  cal_once_a: assert property (@(posedge pclk) disable iff (!presetn)
    if_filter_cal_start |=> !if_filter_cal_start)
    else $error("calibration start longer than one cycle");
  rx_turn_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_packet_done && packet_mode && radio_behavior_ctrl.tx_then_rx_turnaround
      |=> turnaround_to_rx)
    else $error("turnaround to receive missed");
  tx_turn_a: assert property (@(posedge pclk) disable iff (!presetn)
    rx_packet_valid && packet_mode && radio_behavior_ctrl.rx_then_tx_turnaround
      |=> turnaround_to_tx)
    else $error("turnaround to transmit missed");
  rx_turn_en_a: assert property (@(posedge pclk) disable iff (!presetn)
    turnaround_to_rx |-> $past(radio_behavior_ctrl.tx_then_rx_turnaround))
    else $error("turnaround to receive while disabled");
  tx_turn_en_a: assert property (@(posedge pclk) disable iff (!presetn)
    turnaround_to_tx |-> $past(radio_behavior_ctrl.rx_then_tx_turnaround))
    else $error("turnaround to transmit while disabled");

  // External amplifier pins
  lna_rx_a: assert property (@(posedge pclk) disable iff (!presetn)
    in_rx && radio_behavior_ctrl.lna_control_enable |=> lna_pin_out && lna_pin_oe)
    else $error("lna pin low in receive");
  lna_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !radio_behavior_ctrl.lna_control_enable || !awake |=> !lna_pin_oe && !lna_pin_out)
    else $error("lna pin driven while disabled or asleep");
  pa_tx_a: assert property (@(posedge pclk) disable iff (!presetn)
    in_tx && radio_behavior_ctrl.pa_control_enable |=> pa_pin_out && pa_pin_oe)
    else $error("pa pin low in transmit");
  pa_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !radio_behavior_ctrl.pa_control_enable || !awake |=> !pa_pin_oe && !pa_pin_out)
    else $error("pa pin driven while disabled or asleep");

  // Coding, preamble, lock point and IQ trim outputs
  tol_twelve_a: assert property (@(posedge pclk) disable iff (!presetn)
    tol == rmpc_pkg::TOL_MAX_VALID |=> coding.preamble_errors_allowed == '0)
    else $error("tolerance twelve must allow no errors");
  det_on_a: assert property (@(posedge pclk) disable iff (!presetn)
    tol != rmpc_pkg::TOL_OFF |=> coding.preamble_detect_enable)
    else $error("preamble detection off with nonzero tolerance");
  sym_eight_a: assert property (@(posedge pclk) disable iff (!presetn)
    line_coding_cfg.symbol_width != rmpc_pkg::SYM_10BIT |=>
      coding.symbol_bits == rmpc_pkg::SYM_BITS_8)
    else $error("eight-bit symbols expected");
  iq_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 iq_amplitude_trim == $past(iq_gain_trim[6:0]))
    else $error("iq trim output mismatch");
  lock_pre_a: assert property (@(posedge pclk) disable iff (!presetn)
    lock_mode && tol != rmpc_pkg::TOL_OFF |=> lock_after_preamble)
    else $error("lock after preamble missed");
  lock_sync_a: assert property (@(posedge pclk) disable iff (!presetn)
    lock_mode && tol == rmpc_pkg::TOL_OFF |=> lock_on_sync)
    else $error("sync lock missed with tolerance zero");
  no_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
    !lock_mode |=> !lock_after_preamble && !lock_on_sync)
    else $error("lock point outside lock mode");

  cal_seen_c: cover property (@(posedge pclk) disable iff (!presetn) if_filter_cal_start);
  tx_turn_c: cover property (@(posedge pclk) disable iff (!presetn) turnaround_to_tx);
  rx_turn_c: cover property (@(posedge pclk) disable iff (!presetn) turnaround_to_rx);
  lna_on_c: cover property (@(posedge pclk) disable iff (!presetn) lna_pin_out);
  bad_addr_c: cover property (@(posedge pclk) disable iff (!presetn) pslverr);

endmodule : rmpc_cfg

// File: rmpc_cfg_tb_top.sv
// Self-checking bench for the radio mode and packet coding config bank.
// Assumes rmpc_cfg as the top, a zero-wait APB slave, outputs one edge late.
`timescale 1ns/1ps
module rmpc_cfg_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [13:0] paddr = 14'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [2:0] radio_state = 3'h2;
  logic packet_mode = 1'b0;
  logic tx_done = 1'b0;
  logic rx_valid = 1'b0;
  logic [1:0] lock_mode = 2'h0;
  logic [31:0] prdata;
  logic pready, pslverr, sw, rq, ifc, t_rx, t_tx, clt, lap, los;
  logic lna_o, lna_oe, pa_o, pa_oe;
  logic [6:0] trim;
  rmpc_pkg::rmpc_coding_out_t coding;
  int mismatches = 0;
  int compares = 0;
  logic [31:0] rd;
  logic er;
  logic [11:0] idxs [5] = '{12'h119, 12'h11a, 12'h11b, 12'h11c, 12'h11d};
  logic [7:0] masks [5] = '{8'h7f, 8'hff, 8'h0f, 8'h7f, 8'hff};

  always #5 pclk = ~pclk;

  rmpc_cfg dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .radio_state(radio_state),
    .packet_mode(packet_mode), .tx_packet_done(tx_done), .rx_packet_valid(rx_valid),
    .freq_tracking_lock_mode(lock_mode), .smart_wake_enable(sw), .wake_rssi_qualify(rq),
    .if_filter_cal_start(ifc), .turnaround_to_rx(t_rx), .turnaround_to_tx(t_tx),
    .custom_lock_time_enable(clt), .lock_after_preamble(lap), .lock_on_sync(los),
    .iq_amplitude_trim(trim), .coding(coding), .lna_pin_out(lna_o), .lna_pin_oe(lna_oe),
    .pa_pin_out(pa_o), .pa_pin_oe(pa_oe));

  task automatic conclude();
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  function automatic logic [13:0] ba(input logic [11:0] idx);
    return {idx, 2'h0};
  endfunction : ba

  // Request held until the edge where pready is seen high
  task automatic apb(input logic [13:0] a, input logic w, input logic [7:0] d,
                     input logic [3:0] s);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      mismatches++;
      conclude();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [13:0] a, input logic [7:0] e);
    apb(a, 1'b0, 8'h00, 4'h0);
    chk(rd, {24'h0, e});
    chk(32'(er), 32'h0);
    chk(32'(pready), 32'h1);
  endtask : rd_chk

  // Register-derived outputs move one edge after the write lands
  task automatic settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask : settle

  task automatic t_regs();
    for (int i = 0; i < 5; i++) rd_chk(ba(idxs[i]), 8'h00);
    for (int i = 0; i < 5; i++) apb(ba(idxs[i]), 1'b1, 8'hff, 4'h1);
    for (int i = 0; i < 5; i++) rd_chk(ba(idxs[i]), masks[i]);
    settle();
    chk(32'(trim), 32'h7f);
  endtask : t_regs

  task automatic t_refuse();
    apb(14'h478, 1'b0, 8'h00, 4'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    apb(ba(idxs[0]) + 14'h1, 1'b1, 8'h00, 4'h1);
    chk({31'h0, er}, 32'h1);
    apb(ba(idxs[0]), 1'b1, 8'h00, 4'h0);
    rd_chk(ba(idxs[0]), 8'h7f);
  endtask : t_refuse

  task automatic t_mode();
    for (int b = 0; b < 8; b++) begin
      apb(ba(idxs[1]), 1'b1, 8'h01 << b, 4'h1);
      settle();
      chk(32'({sw, rq, clt}), 32'({b == 7, b == 5, b == 2}));
    end
    apb(ba(idxs[1]), 1'b1, 8'h03, 4'h1);
    for (int st = 0; st < 5; st++) begin
      @(posedge pclk);
      radio_state <= 3'(st);
      settle();
      chk(32'({lna_oe, lna_o, pa_oe, pa_o}), 32'({st != 0, st == 3, st != 0, st == 4}));
    end
    apb(ba(idxs[1]), 1'b1, 8'h00, 4'h1);
    settle();
    chk(32'({lna_oe, lna_o, pa_oe, pa_o}), 32'h0);
  endtask : t_mode

  // Counts pulses of {cal, to_rx, to_tx}, two bits each, after one event
  task automatic ev(input int kind, input logic [5:0] e);
    logic [5:0] c;
    c = 6'h0;
    @(posedge pclk);
    if (kind == 0) radio_state <= 3'h1;
    if (kind == 1) tx_done <= 1'b1;
    if (kind == 2) rx_valid <= 1'b1;
    @(posedge pclk);
    radio_state <= 3'h2;
    tx_done <= 1'b0;
    rx_valid <= 1'b0;
    // Sample from the edge that ends the event, where turnaround pulses stand
    repeat (4) begin
      #1;
      c = c + {1'b0, ifc, 1'b0, t_rx, 1'b0, t_tx};
      @(posedge pclk);
    end
    chk(32'(c), 32'(e));
  endtask : ev

  task automatic t_events();
    @(posedge pclk);
    radio_state <= 3'h2;
    packet_mode <= 1'b1;
    apb(ba(idxs[1]), 1'b1, 8'h58, 4'h1);
    settle();
    ev(0, 6'b010000);
    ev(1, 6'b000100);
    ev(2, 6'b000001);
    packet_mode <= 1'b0;
    ev(1, 6'b000000);
    ev(2, 6'b000000);
    packet_mode <= 1'b1;
    apb(ba(idxs[1]), 1'b1, 8'h00, 4'h1);
    settle();
    ev(0, 6'b000000);
    ev(1, 6'b000000);
    ev(2, 6'b000000);
  endtask : t_events

  task automatic t_tol();
    logic [3:0] errs;
    @(posedge pclk);
    lock_mode <= 2'h3;
    for (int code = 0; code < 13; code++) begin
      errs = (code >= 8) ? 4'(12 - code) : 4'h0;
      apb(ba(idxs[2]), 1'b1, 8'(code), 4'h1);
      settle();
      chk(32'({coding.preamble_detect_enable, coding.preamble_errors_allowed}),
          32'({code != 0, errs}));
      chk(32'({lap, los}), 32'({code != 0, code == 0}));
    end
    @(posedge pclk);
    lock_mode <= 2'h2;
    settle();
    chk(32'({lap, los}), 32'h0);
  endtask : t_tol

  task automatic t_coding();
    logic [7:0] v [7] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h11, 8'h01, 8'h00};
    logic [7:0] p [4] = '{8'h00, 8'h03, 8'h80, 8'hff};
    for (int i = 0; i < 7; i++) begin
      apb(ba(idxs[3]), 1'b1, v[i], 4'h1);
      settle();
      chk(32'({coding.biphase_coding_enable, coding.custom_crc_select,
               coding.dc_balanced_coding_enable, coding.whitening_enable, coding.symbol_bits}),
          32'({v[i][6:3], (v[i][2:0] == 3'h1) ? 4'ha : 4'h8}));
    end
    for (int i = 0; i < 4; i++) begin
      apb(ba(idxs[4]), 1'b1, p[i], 4'h1);
      settle();
      chk(32'(coding.preamble_bits), 32'({p[i], 3'h0}));
    end
  endtask : t_coding

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_refuse();
    t_mode();
    t_events();
    t_tol();
    t_coding();
    conclude();
  end
endmodule : rmpc_cfg_tb_top

// File: rmpc_pkg.sv
// Package for the radio mode and packet coding configuration bank.
// Assumes APB with 32-bit data; byte registers sit in the low lane.
package rmpc_pkg;
  // Printed offsets are register indices; byte address is four times each.
  localparam logic [11:0] IDX_IQ_GAIN_TRIM = 12'h119;
  localparam logic [11:0] IDX_RADIO_BEHAVIOR_CTRL = 12'h11a;
  localparam logic [11:0] IDX_PREAMBLE_ERROR_TOLERANCE = 12'h11b;
  localparam logic [11:0] IDX_LINE_CODING_CFG = 12'h11c;
  localparam logic [11:0] IDX_PREAMBLE_BYTE_COUNT = 12'h11d;
  localparam int ADDR_W = 14;
  localparam logic [1:0] ADDR_LSB_ZERO = 2'h0;
  // Reset values
  localparam logic [7:0] RST_IQ_GAIN_TRIM = 8'h00;
  localparam logic [7:0] RST_BEHAVIOR = 8'h00;
  localparam logic [7:0] RST_PREAMBLE_TOL = 8'h00;
  localparam logic [7:0] RST_LINE_CODING = 8'h00;
  localparam logic [7:0] RST_PREAMBLE_BYTES = 8'h00;
  // Writable masks; reserved bits read zero
  localparam logic [7:0] MASK_IQ_GAIN_TRIM = 8'h7f;
  localparam logic [7:0] MASK_PREAMBLE_TOL = 8'h0f;
  localparam logic [7:0] MASK_LINE_CODING = 8'h7f;
  localparam logic [7:0] MASK_FULL = 8'hff;
  // Preamble tolerance encodings
  localparam logic [3:0] TOL_OFF = 4'h0;
  localparam logic [3:0] TOL_MIN_VALID = 4'h8;
  localparam logic [3:0] TOL_MAX_VALID = 4'hc;
  localparam logic [3:0] TOL_PAIRS_OBSERVED = 4'hc;
  // Symbol width encodings
  localparam logic [2:0] SYM_8BIT = 3'h0;
  localparam logic [2:0] SYM_10BIT = 3'h1;
  localparam logic [3:0] SYM_BITS_8 = 4'h8;
  localparam logic [3:0] SYM_BITS_10 = 4'ha;
  // Radio state codes as seen from the state machine outside
  typedef enum logic [2:0] {
    RMPC_ST_SLEEP = 3'b000,
    RMPC_ST_OFF = 3'b001,
    RMPC_ST_ON = 3'b010,
    RMPC_ST_RX = 3'b011,
    RMPC_ST_TX = 3'b100
  } rmpc_state_t;
  // Frequency tracking modes
  localparam logic [1:0] AFC_LOCK = 2'h3;
  typedef struct packed {
    logic smart_wake_enable;
    logic if_filter_cal_enable;
    logic wake_rssi_qualify;
    logic tx_then_rx_turnaround;
    logic rx_then_tx_turnaround;
    logic custom_lock_time_enable;
    logic lna_control_enable;
    logic pa_control_enable;
  } rmpc_behavior_t;
  typedef struct packed {
    logic reserved;
    logic biphase_coding_enable;
    logic custom_crc_select;
    logic dc_balanced_coding_enable;
    logic whitening_enable;
    logic [2:0] symbol_width;
  } rmpc_coding_t;
  typedef struct packed {
    logic biphase_coding_enable;
    logic custom_crc_select;
    logic dc_balanced_coding_enable;
    logic whitening_enable;
    logic [3:0] symbol_bits;
    logic preamble_detect_enable;
    logic [3:0] preamble_errors_allowed;
    logic [10:0] preamble_bits;
  } rmpc_coding_out_t;
endpackage : rmpc_pkg
